// [core/ssp_pkg.sv]
// Function
// [R1] Port uses serial in, serial out, serial clock and active-low select lines.
// [R2] Every transfer is full duplex: one byte out while one byte comes in.
// [R3] Master or slave role is chosen by configuration.
// [R4] Only the master starts a transfer; the slave never shifts on its own.
// [R5] Master drives the serial clock; a slave shifts only on the external clock.
// [R6] Only one select pin exists; further slaves need general-purpose outputs.
// [R7] Select pin acts as slave select when enabled, floats when disabled.
// [R8] Interface enable turns the port on or off, keeping stored configuration.
// [R9] Mode field chooses SPI or two-wire function sharing pins and registers. No two-wire logic here: code 6 only leaves the SPI logic idle.
// [R10] One data register holds the byte to send and the byte received.
// [R11] A transfer sends the byte loaded in the data register beforehand.
// [R12] The received byte is read back from the data register.
// [R13] Bit order selectable: least or most significant bit first.
// [R14] Capture edge selectable as rising or falling.
// [R15] The two-wire control register has no effect on SPI operation.
// [R16] Mode codes 0-4 master with five clock sources, 5 slave, 6 two-wire, 7 off.
// [R17] Data write during a transfer is ignored and sets the collision flag.
// [R18] Done flag set by hardware at transfer end, cleared by software.
// [R19] Slave select released mid-byte sets incomplete flag and done flag.
// [R20] Each transfer shifts exactly eight bits before the done flag rises.
package ssp_pkg;

    ////////////////////////////////////////////////////////////////////////////////
    // Register map, byte addresses
    localparam logic [7:0] ADDR_CTRL0 = 8'h00;
    localparam logic [7:0] ADDR_CTRL2 = 8'h04;
    localparam logic [7:0] ADDR_DATA = 8'h08;

    // Mode field codes
    localparam logic [2:0] MODE_MST_DIV4 = 3'h0;
    localparam logic [2:0] MODE_MST_DIV16 = 3'h1;
    localparam logic [2:0] MODE_MST_DIV64 = 3'h2;
    localparam logic [2:0] MODE_MST_SUB = 3'h3;
    localparam logic [2:0] MODE_MST_TMR = 3'h4;
    localparam logic [2:0] MODE_SLAVE = 3'h5;
    localparam logic [2:0] MODE_TWOWIRE = 3'h6;
    localparam logic [2:0] MODE_OFF = 3'h7;

    // Values after reset
    localparam logic [7:0] CTRL0_RST = 8'hE0;
    localparam logic [7:0] CTRL2_RST = 8'h00;
    localparam logic [7:0] DATA_RST = 8'h00;

    // Half periods of the master clock in system cycles
    localparam logic [5:0] HALF_DIV4 = 6'h02;
    localparam logic [5:0] HALF_DIV16 = 6'h08;
    localparam logic [5:0] HALF_DIV64 = 6'h20;

    // Transfer length
    localparam logic [3:0] BITS_PER_XFER = 4'h8;
    localparam logic [4:0] EDGES_PER_XFER = 5'h10;

    ////////////////////////////////////////////////////////////////////////////////
    typedef struct packed {
        logic [2:0] operatingModeSel;
        logic unused4;
        logic [1:0] twowireDebounceSel;
        logic ifaceEnable;
        logic slaveIncompleteFlag;
    } ssp_ctrl0_t;

    typedef struct packed {
        logic [1:0] spare;
        logic clockIdleLevelSel;
        logic captureEdgeSel;
        logic shiftOrderSel;
        logic selectPinEnable;
        logic writeCollisionFlag;
        logic transferDoneFlag;
    } ssp_ctrl2_t;

    typedef struct packed {
        logic sdi;
        logic sck;
        logic scsN;
    } ssp_pins_in_t;

    typedef struct packed {
        logic sdoOut;
        logic sdoOe;
        logic sckOut;
        logic sckOe;
        logic scsNOut;
        logic scsNOe;
    } ssp_pins_out_t;

endpackage

// [core/ssp_spi_port.sv]
`timescale 1ns/10ps
module ssp_spi_port (
    // Clock and reset
    input wire logic mclk,
    input wire logic srst,
    // AHB-Lite slave
    input wire logic hsel,
    input wire logic [31:0] haddr,
    input wire logic [1:0] htrans,
    input wire logic hwrite,
    input wire logic [2:0] hsize,
    input wire logic [31:0] hwdata,
    input wire logic hready,
    output logic hreadyout,
    output logic [31:0] hrdata,
    output logic hresp,
    // Serial pins, asynchronous inputs
    input ssp_pkg::ssp_pins_in_t pinIn,
    output ssp_pkg::ssp_pins_out_t pinOut,
    // Master clock sources
    input wire logic subClkIn,
    input wire logic timerMatch
);

    typedef enum logic {ST_IDLE, ST_RUN} ssp_state_t;

    function automatic logic [7:0] shiftIn(input logic [7:0] sh, input logic bitIn,
                                           input logic msbFirst);
        shiftIn = msbFirst ? {sh[6:0], bitIn} : {bitIn, sh[7:1]};
    endfunction

    function automatic logic outBit(input logic [7:0] sh, input logic msbFirst);
        outBit = msbFirst ? sh[7] : sh[0];
    endfunction

    ////////////////////////////////////////////////////////////////////////////////
    // Synchronisers; first stages feed only the second
    ssp_pkg::ssp_pins_in_t meta_ff, sync_ff;
    logic sckDly_ff, scsNDly_ff;
    logic subMeta_ff, subSync_ff, subDly_ff;

    always_ff @(posedge mclk) begin
        if (srst) begin
            meta_ff <= 3'h7;
            sync_ff <= 3'h7;
            sckDly_ff <= 1'h1;
            scsNDly_ff <= 1'h1;
            subMeta_ff <= 1'h0;
            subSync_ff <= 1'h0;
            subDly_ff <= 1'h0;
        end else begin
            meta_ff <= pinIn;
            sync_ff <= meta_ff;
            sckDly_ff <= sync_ff.sck;
            scsNDly_ff <= sync_ff.scsN;
            subMeta_ff <= subClkIn;
            subSync_ff <= subMeta_ff;
            subDly_ff <= subSync_ff;
        end
    end

    ////////////////////////////////////////////////////////////////////////////////
    // State
    ssp_pkg::ssp_ctrl0_t ctrl0_ff, nxt_ctrl0;
    ssp_pkg::ssp_ctrl2_t ctrl2_ff, nxt_ctrl2;
    logic [7:0] shift_ff, nxt_shift;
    logic sdoBit_ff, nxt_sdoBit;
    ssp_state_t state_ff, nxt_state;
    logic [5:0] divCnt_ff, nxt_divCnt;
    logic [4:0] edgeCnt_ff, nxt_edgeCnt;
    logic [3:0] bitCnt_ff, nxt_bitCnt;
    logic sckOut_ff, nxt_sckOut;
    logic scsNOut_ff, nxt_scsNOut;
    logic sdoOe_ff, nxt_sdoOe;
    logic sckOe_ff, nxt_sckOe;
    logic scsNOe_ff, nxt_scsNOe;
    logic wrPend_ff, nxt_wrPend;
    logic rdPend_ff, nxt_rdPend;
    logic [7:0] addr_ff, nxt_addr;
    logic hreadyout_ff, nxt_hreadyout;
    logic [31:0] hrdata_ff, nxt_hrdata;

    logic masterMode, slaveMode, slaveSel, busy, captureRising;
    logic tick, edgeSeen, edgeRise, doCapture, doShift;
    logic accept, wrData;
    logic [5:0] halfPeriod;

    always_comb begin
        nxt_ctrl0 = ctrl0_ff;
        nxt_ctrl2 = ctrl2_ff;
        nxt_shift = shift_ff;
        nxt_sdoBit = sdoBit_ff;
        nxt_state = state_ff;
        nxt_divCnt = divCnt_ff;
        nxt_edgeCnt = edgeCnt_ff;
        nxt_bitCnt = bitCnt_ff;
        nxt_sckOut = sckOut_ff;
        nxt_scsNOut = scsNOut_ff;
        nxt_hrdata = hrdata_ff;
        edgeSeen = 1'h0;
        edgeRise = 1'h0;
        tick = 1'h0;
        halfPeriod = ssp_pkg::HALF_DIV4;

        // Only codes 0-4 and 5 reach the SPI logic; 6 and 7 leave it idle
        masterMode = ctrl0_ff.ifaceEnable && (ctrl0_ff.operatingModeSel <= ssp_pkg::MODE_MST_TMR); // [R3] [R8] [R9] [R16]
        slaveMode = ctrl0_ff.ifaceEnable && (ctrl0_ff.operatingModeSel == ssp_pkg::MODE_SLAVE); // [R3] [R16]
        // Select disabled means the slave is always addressed
        slaveSel = slaveMode && (!ctrl2_ff.selectPinEnable || !sync_ff.scsN); // [R7]
        busy = (state_ff == ST_RUN) || (slaveMode && bitCnt_ff != 4'h0);
        captureRising = (ctrl2_ff.clockIdleLevelSel == ctrl2_ff.captureEdgeSel); // [R14]

        // AHB address phase
        accept = hsel && htrans[1] && hready;
        nxt_wrPend = accept && hwrite;
        nxt_rdPend = accept && !hwrite;
        nxt_addr = accept ? haddr[7:0] : addr_ff;
        // Reads take one wait state so a write just before is visible
        nxt_hreadyout = !(accept && !hwrite);
        wrData = wrPend_ff && (addr_ff == ssp_pkg::ADDR_DATA);

        ////////////////////////////////////////////////////////////////////////////////
        // Register writes, data phase
        if (wrPend_ff && addr_ff == ssp_pkg::ADDR_CTRL0) begin
            nxt_ctrl0 = ssp_pkg::ssp_ctrl0_t'(hwdata[7:0]);
            nxt_ctrl0.unused4 = 1'h0;
        end
        if (wrPend_ff && addr_ff == ssp_pkg::ADDR_CTRL2) begin
            nxt_ctrl2 = ssp_pkg::ssp_ctrl2_t'(hwdata[7:0]); // [R18]
        end
        if (wrData) begin
            if (busy) begin
                nxt_ctrl2.writeCollisionFlag = 1'h1; // [R17]
            end else begin
                nxt_shift = hwdata[7:0]; // [R10] [R11]
                nxt_sdoBit = outBit(hwdata[7:0], ctrl2_ff.shiftOrderSel);
                if (masterMode) begin
                    // Master starts only on a data write
                    nxt_state = ST_RUN; // [R4]
                    nxt_divCnt = 6'h00;
                    nxt_edgeCnt = 5'h00;
                    nxt_bitCnt = 4'h0;
                    nxt_scsNOut = 1'h0;
                end
            end
        end

        ////////////////////////////////////////////////////////////////////////////////
        // Master clock generation
        unique case (ctrl0_ff.operatingModeSel)
            ssp_pkg::MODE_MST_DIV16: halfPeriod = ssp_pkg::HALF_DIV16;
            ssp_pkg::MODE_MST_DIV64: halfPeriod = ssp_pkg::HALF_DIV64;
            default: halfPeriod = ssp_pkg::HALF_DIV4;
        endcase
        if (state_ff == ST_RUN) begin
            unique case (ctrl0_ff.operatingModeSel)
                ssp_pkg::MODE_MST_SUB: tick = subSync_ff ^ subDly_ff;
                ssp_pkg::MODE_MST_TMR: tick = timerMatch;
                default: begin
                    tick = (divCnt_ff == halfPeriod - 6'h01);
                    nxt_divCnt = tick ? 6'h00 : divCnt_ff + 6'h01;
                end
            endcase
        end

        if (state_ff == ST_RUN && !masterMode) begin
            // Disabled or mode moved off codes 0-4 mid-byte: drop the transfer, keep settings
            nxt_state = ST_IDLE; // [R8]
            nxt_scsNOut = 1'h1;
        end else if (state_ff == ST_RUN && tick) begin
            nxt_sckOut = !sckOut_ff; // [R5]
            edgeSeen = 1'h1;
            edgeRise = !sckOut_ff;
            nxt_edgeCnt = edgeCnt_ff + 5'h01;
            if (edgeCnt_ff == ssp_pkg::EDGES_PER_XFER - 5'h01) begin
                nxt_state = ST_IDLE;
                nxt_scsNOut = 1'h1;
                nxt_ctrl2.transferDoneFlag = 1'h1; // [R18] [R20]
            end
        end else if (state_ff == ST_IDLE) begin
            nxt_sckOut = !ctrl2_ff.clockIdleLevelSel;
        end

        // Slave: edges of the external clock only
        if (slaveSel && (sync_ff.sck != sckDly_ff)) begin
            edgeSeen = 1'h1; // [R5]
            edgeRise = sync_ff.sck;
        end

        ////////////////////////////////////////////////////////////////////////////////
        // Shift engine shared by both roles
        doCapture = edgeSeen && (edgeRise == captureRising);
        doShift = edgeSeen && (edgeRise != captureRising);
        if (doCapture) begin
            nxt_shift = shiftIn(shift_ff, sync_ff.sdi, ctrl2_ff.shiftOrderSel); // [R2] [R13]
            nxt_bitCnt = bitCnt_ff + 4'h1;
            if (slaveMode && bitCnt_ff == ssp_pkg::BITS_PER_XFER - 4'h1) begin
                nxt_bitCnt = 4'h0;
                nxt_ctrl2.transferDoneFlag = 1'h1; // [R18] [R20]
            end
        end
        if (doShift) begin
            nxt_sdoBit = outBit(shift_ff, ctrl2_ff.shiftOrderSel); // [R2] [R13]
        end
        if (masterMode && state_ff == ST_IDLE) begin
            nxt_bitCnt = 4'h0;
        end

        // Select released before eight bits arrived
        if (slaveMode && ctrl2_ff.selectPinEnable && sync_ff.scsN && !scsNDly_ff
                && bitCnt_ff != 4'h0) begin
            nxt_bitCnt = 4'h0;
            nxt_ctrl0.slaveIncompleteFlag = 1'h1; // [R19]
            nxt_ctrl2.transferDoneFlag = 1'h1; // [R19]
        end
        if (!slaveMode && !masterMode) begin
            nxt_bitCnt = 4'h0;
        end

        ////////////////////////////////////////////////////////////////////////////////
        // Pin drivers; two-wire code and disable float every SPI pin
        nxt_sdoOe = masterMode || slaveSel; // [R1] [R8]
        nxt_sckOe = masterMode; // [R5]
        nxt_scsNOe = masterMode && ctrl2_ff.selectPinEnable; // [R6] [R7]

        // Read data, loaded in the wait cycle
        if (rdPend_ff) begin
            unique case (addr_ff)
                ssp_pkg::ADDR_CTRL0: nxt_hrdata = {24'h000000, nxt_ctrl0};
                ssp_pkg::ADDR_CTRL2: nxt_hrdata = {24'h000000, nxt_ctrl2};
                ssp_pkg::ADDR_DATA: nxt_hrdata = {24'h000000, shift_ff}; // [R12]
                default: nxt_hrdata = 32'h00000000; // [R15]
            endcase
        end
    end

    always_ff @(posedge mclk) begin
        if (srst) begin
            ctrl0_ff <= ssp_pkg::CTRL0_RST;
            ctrl2_ff <= ssp_pkg::CTRL2_RST;
            shift_ff <= ssp_pkg::DATA_RST;
            sdoBit_ff <= 1'h0;
            state_ff <= ST_IDLE;
            divCnt_ff <= 6'h00;
            edgeCnt_ff <= 5'h00;
            bitCnt_ff <= 4'h0;
            sckOut_ff <= 1'h1;
            scsNOut_ff <= 1'h1;
            sdoOe_ff <= 1'h0;
            sckOe_ff <= 1'h0;
            scsNOe_ff <= 1'h0;
            wrPend_ff <= 1'h0;
            rdPend_ff <= 1'h0;
            addr_ff <= 8'h00;
            hreadyout_ff <= 1'h1;
            hrdata_ff <= 32'h00000000;
        end else begin
            ctrl0_ff <= nxt_ctrl0;
            ctrl2_ff <= nxt_ctrl2;
            shift_ff <= nxt_shift;
            sdoBit_ff <= nxt_sdoBit;
            state_ff <= nxt_state;
            divCnt_ff <= nxt_divCnt;
            edgeCnt_ff <= nxt_edgeCnt;
            bitCnt_ff <= nxt_bitCnt;
            sckOut_ff <= nxt_sckOut;
            scsNOut_ff <= nxt_scsNOut;
            sdoOe_ff <= nxt_sdoOe;
            sckOe_ff <= nxt_sckOe;
            scsNOe_ff <= nxt_scsNOe;
            wrPend_ff <= nxt_wrPend;
            rdPend_ff <= nxt_rdPend;
            addr_ff <= nxt_addr;
            hreadyout_ff <= nxt_hreadyout;
            hrdata_ff <= nxt_hrdata;
        end
    end

    ////////////////////////////////////////////////////////////////////////////////
    // Outputs from flops, hresp tied low; hsize is unused since only words are mapped
    assign hreadyout = hreadyout_ff;
    assign hrdata = hrdata_ff;
    assign hresp = 1'h0;
    assign pinOut.sdoOut = sdoBit_ff;
    assign pinOut.sdoOe = sdoOe_ff;
    assign pinOut.sckOut = sckOut_ff;
    assign pinOut.sckOe = sckOe_ff;
    assign pinOut.scsNOut = scsNOut_ff;
    assign pinOut.scsNOe = scsNOe_ff;

endmodule // ssp_spi_port

// [verif/ssp_spi_port_monitor.sv]
`timescale 1ns/10ps
module ssp_spi_port_monitor (
    // Clock and reset
    input wire logic mclk,
    input wire logic srst,
    // Bus
    input wire logic hsel,
    input wire logic [31:0] haddr,
    input wire logic [1:0] htrans,
    input wire logic hwrite,
    input wire logic [2:0] hsize,
    input wire logic [31:0] hwdata,
    input wire logic hready,
    input wire logic hreadyout,
    input wire logic [31:0] hrdata,
    input wire logic hresp,
    // Pins
    input ssp_pkg::ssp_pins_in_t pinIn,
    input ssp_pkg::ssp_pins_out_t pinOut,
    input wire logic subClkIn,
    input wire logic timerMatch
);
    default clocking @(posedge mclk); endclocking
    default disable iff (srst);
    logic prevSck_ff, prevScs_ff, nxt_prevSck, nxt_prevScs;
    logic [5:0] nTog_ff, nxt_nTog;
    logic take, scsN, sck;
    assign take = hsel && htrans[1] && hready;
    assign scsN = pinOut.scsNOut;
    assign sck = pinOut.sckOut;
    ////////////////////////////////////////////////////////////////////////////////
    // Toggles per frame, cleared when select falls
    always_comb begin
        nxt_prevSck = sck;
        nxt_prevScs = scsN;
        nxt_nTog = nTog_ff;
        if (!scsN && prevScs_ff) nxt_nTog = 6'h00;
        else if (sck != prevSck_ff) nxt_nTog = nTog_ff + 6'h01;
    end
    always_ff @(posedge mclk) begin
        prevSck_ff <= nxt_prevSck;
        prevScs_ff <= nxt_prevScs;
        nTog_ff <= srst ? 6'h00 : nxt_nTog;
    end
    ////////////////////////////////////////////////////////////////////////////////
    property p_rd_lat; take && !hwrite |=> !hreadyout ##1 hreadyout; endproperty
    a_rd_lat: assert property (p_rd_lat) else $error("read wait state wrong");
    property p_rd_zero; hreadyout && !$past(hreadyout) |-> hrdata[31:8] == 24'h0; endproperty
    a_rd_zero: assert property (p_rd_zero) else $error("upper read bits set");
    property p_start;
        take && hwrite && haddr[7:0] == ssp_pkg::ADDR_DATA && scsN && pinOut.sckOe
            |-> ##[1:3] !scsN;
    endproperty
    a_start: assert property (p_start) else $error("data write did not start");
    property p_len; $rose(scsN) |=> nTog_ff == 6'h10; endproperty
    a_len: assert property (p_len) else $error("frame toggle count wrong");
    property p_end; $fell(scsN) |-> ##[16:1000] $rose(scsN); endproperty
    a_end: assert property (p_end) else $error("frame never ended");
    property p_sck_drv; !scsN && pinOut.scsNOe |-> pinOut.sckOe; endproperty
    a_sck_drv: assert property (p_sck_drv) else $error("master clock not driven");
    property p_idle; scsN && $past(scsN) && $stable(pinOut.sckOe) |-> $stable(sck); endproperty
    a_idle: assert property (p_idle) else $error("clock moved outside frame");
    property p_sdo;
        !scsN && $past(!scsN) && $changed(pinOut.sdoOut) |-> $changed(sck);
    endproperty
    a_sdo: assert property (p_sdo) else $error("data moved off shift edge");
    c_rd: cover property (take && !hwrite);
    c_frame: cover property ($rose(scsN));
    c_coll: cover property (!scsN ##1 take && hwrite);
endmodule // ssp_spi_port_monitor

bind ssp_spi_port ssp_spi_port_monitor i_ssp_spi_port_monitor (.mclk, .srst, .hsel, .haddr,
    .htrans, .hwrite, .hsize, .hwdata, .hready, .hreadyout, .hrdata, .hresp, .pinIn, .pinOut,
    .subClkIn, .timerMatch);

// [verif/ssp_spi_partner.sv]
`timescale 1ns/10ps
module ssp_spi_partner (
    // Wires from the master
    input wire logic scsN,
    input wire logic sck,
    input wire logic sdo,
    // Set up by the bench
    input wire logic msbFirst,
    input wire logic capRise,
    input wire logic [7:0] txByte,
    // Toward the master; received byte to the bench
    output logic sdi,
    output logic [7:0] rxByte
);
    // Starts full so idle clock moves before the first frame shift nothing
    int n = 8;
    initial sdi = 1'b0;
    initial rxByte = 8'h00;
    // Shifts only while selected, on the master's clock
    always @(negedge scsN) begin
        n = 0;
        sdi = msbFirst ? txByte[7] : txByte[0];
    end
    // Released line must not keep the last bit
    always @(posedge scsN) sdi = ~sdi;
    always @(sck) begin
        // On rising capture the last capture edge and select release share a time step, so no select test here
        if (sck === capRise && n < 8) begin
            rxByte = msbFirst ? {rxByte[6:0], sdo} : {sdo, rxByte[7:1]};
            n++;
            if (n < 8) sdi = msbFirst ? txByte[7 - n] : txByte[n];
        end
    end
endmodule // ssp_spi_partner

// [verif/ssp_spi_port_tb.sv]
`timescale 1ns/10ps
`define CHK(g, e) begin testsRun++; if ((g) !== (e)) begin nMismatch++; \
    $display("wrong value at %0t: got %h want %h", $time, g, e); end end
module ssp_spi_port_tb;
    logic mclk = 0, srst = 1, hsel = 0, hwrite = 0, hreadyout, hresp;
    logic [31:0] haddr = 0, hwdata = 0, hrdata, lfsr = 32'hD2B6;
    logic [1:0] htrans = 0;
    logic [2:0] hsize = 3'h2;
    ssp_pkg::ssp_pins_in_t pinIn;
    ssp_pkg::ssp_pins_out_t pinOut;
    logic pSdi, pMsb = 0, pCapRise = 1, rdData = 0, bSck = 1, bScsN = 1;
    logic [7:0] pTx = 0, pRx, c2, tx;
    logic [7:0] expQ[$];
    int nMismatch = 0, testsRun = 0, cyc = 0;
    assign pinIn = '{sdi: pSdi, sck: bSck, scsN: bScsN};
    always #2.5 mclk = ~mclk;
    ssp_spi_port i_ssp_spi_port (.mclk(mclk), .srst(srst), .hsel(hsel), .haddr(haddr),
        .htrans(htrans), .hwrite(hwrite), .hsize(hsize), .hwdata(hwdata), .hready(hreadyout),
        .hreadyout(hreadyout), .hrdata(hrdata), .hresp(hresp), .pinIn(pinIn), .pinOut(pinOut),
        .subClkIn(1'b0), .timerMatch(1'b0));
    ssp_spi_partner i_ssp_spi_partner (.scsN(pinOut.scsNOut), .sck(pinOut.sckOut),
        .sdo(pinOut.sdoOut), .msbFirst(pMsb), .capRise(pCapRise), .txByte(pTx), .sdi(pSdi),
        .rxByte(pRx));
    ////////////////////////////////////////////////////////////////////////////////
    function automatic logic [31:0] nextRand(input logic [31:0] s);
        return {s[30:0], s[31] ^ s[21] ^ s[1] ^ s[0]};
    endfunction
    task automatic testDone();
        if (nMismatch == 0 && testsRun > 0) $display("*** PASS ***");
        else $display("*** FAIL ***");
        $finish;
    endtask
    task automatic xfer(input logic [7:0] a, input logic w, input logic [7:0] d);
        haddr <= {24'h0, a};
        htrans <= 2'b10;
        hwrite <= w;
        do @(posedge mclk); while (!hreadyout);
        htrans <= 2'b00;
        hwdata <= {24'h0, d};
        do @(posedge mclk); while (!hreadyout);
    endtask
    task automatic rd(input logic [7:0] a, input logic [7:0] e);
        expQ.push_back(e);
        xfer(a, 1'b0, 8'h00);
    endtask
    task automatic waitDone();
        int n;
        n = 0;
        while (pinOut.scsNOut !== 1'b1 && n < 2000) begin
            @(posedge mclk);
            n++;
        end
        if (n >= 2000) nMismatch++;
    endtask
    ////////////////////////////////////////////////////////////////////////////////
    // Read data taken at the edge that ends the data phase
    always @(posedge mclk) begin
        if (rdData && hreadyout) `CHK(hrdata, {24'h0, expQ.pop_front()})
        if (hsel && htrans[1] && hreadyout) rdData = !hwrite;
        else if (hreadyout) rdData = 0;
        cyc++;
        if (cyc == 60000) begin
            nMismatch++;
            testDone();
        end
    end
    initial begin
        repeat (8) @(posedge mclk);
        srst <= 1'b0;
        hsel <= 1'b1;
        rd(ssp_pkg::ADDR_CTRL0, ssp_pkg::CTRL0_RST);
        rd(ssp_pkg::ADDR_CTRL2, ssp_pkg::CTRL2_RST);
        rd(ssp_pkg::ADDR_DATA, ssp_pkg::DATA_RST);
        xfer(8'h0C, 1'b1, 8'hFF);
        rd(8'h0C, 8'h00);
        for (int i = 0; i < 4; i++) begin
            c2 = {3'b000, i[0], i[1], 3'b100};
            pCapRise <= !i[0];
            pMsb <= i[1];
            lfsr = nextRand(lfsr);
            pTx <= lfsr[15:8];
            tx = lfsr[7:0];
            xfer(ssp_pkg::ADDR_CTRL2, 1'b1, c2);
            // Capture on the first edge needs the slower clock to cover the input sync lag
            xfer(ssp_pkg::ADDR_CTRL0, 1'b1, {i[0] ? ssp_pkg::MODE_MST_DIV16 :
                ssp_pkg::MODE_MST_DIV4, 5'b00010});
            xfer(ssp_pkg::ADDR_DATA, 1'b1, tx);
            // Second write lands mid-frame and must be dropped
            xfer(ssp_pkg::ADDR_DATA, 1'b1, ~tx);
            waitDone();
            rd(ssp_pkg::ADDR_CTRL2, c2 | 8'h03);
            rd(ssp_pkg::ADDR_DATA, pTx);
            `CHK(pRx, tx)
            xfer(ssp_pkg::ADDR_CTRL2, 1'b1, c2);
            rd(ssp_pkg::ADDR_CTRL2, c2);
        end
        xfer(ssp_pkg::ADDR_CTRL0, 1'b1, 8'h20);
        rd(ssp_pkg::ADDR_CTRL0, 8'h20);
        rd(ssp_pkg::ADDR_CTRL2, c2);
        xfer(ssp_pkg::ADDR_CTRL0, 1'b1, {ssp_pkg::MODE_OFF, 5'b00010});
        xfer(ssp_pkg::ADDR_DATA, 1'b1, 8'h5A);
        rd(ssp_pkg::ADDR_DATA, 8'h5A);
        `CHK({pinOut.sckOe, pinOut.scsNOe}, 2'b00)
        // Slave: select dropped after three bits
        xfer(ssp_pkg::ADDR_CTRL2, 1'b1, 8'h04);
        xfer(ssp_pkg::ADDR_CTRL0, 1'b1, {ssp_pkg::MODE_SLAVE, 5'b00010});
        bScsN <= 1'b0;
        repeat (10) @(posedge mclk);
        `CHK({pinOut.sdoOe, pinOut.sckOe}, 2'b10)
        for (int k = 0; k < 3; k++) begin
            bSck <= 1'b0;
            repeat (10) @(posedge mclk);
            bSck <= 1'b1;
            repeat (10) @(posedge mclk);
        end
        bScsN <= 1'b1;
        repeat (10) @(posedge mclk);
        rd(ssp_pkg::ADDR_CTRL0, {ssp_pkg::MODE_SLAVE, 5'b00011});
        rd(ssp_pkg::ADDR_CTRL2, 8'h05);
        repeat (4) @(posedge mclk);
        testDone();
    end
endmodule // ssp_spi_port_tb
